// [core/agl_loop.sv]
// automatic gain loop for two receiver channels with apb registers
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
//
// Behaviour
// - per channel three gain bits plus strobe
// - strobe when gain word changes
// - channel strobes are independent
// - strobes asserted during master reset, sync-in
// - absolute value, two-stage comb, decimate eight
// - comb order 1 or 2 narrows bandwidth
// - nine-bit level to five-bit float code
// - exponent is leading-one position minus one
// - mantissa is two bits below leading one
// - float code addresses 32x8 software table
// - two-bit loop gain shifts table output
// - shifted error added into 11-bit integrator
// - integrator loads from own initial register
// - integrator top eight bits readable
// - integrator top three bits are gain
// - integrator saturates at zero and maximum
// - exponent is inverse of gain word
// - fixed gain drives inverted initial msbs
// - exponent routed unless inhibit set
// - exponent delayed to match analog step
// - mixer placed in 22-bit field by exponent
module agl_loop
    import agl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device control pins
    input wire logic master_reset_n,
    input wire logic sync_in_n,
    // converter samples and mixer outputs
    input wire logic [ADC_W-1:0] adc_a,
    input wire logic [ADC_W-1:0] adc_b,
    input wire logic [MIX_W-1:0] mixer_a,
    input wire logic [MIX_W-1:0] mixer_b,
    // amplifier interface
    output logic [GAIN_W-1:0] analog_gain_word_a,
    output logic [GAIN_W-1:0] analog_gain_word_b,
    output logic gain_latch_strobe_a,
    output logic gain_latch_strobe_b,
    // digital gain compensation
    output logic [GAIN_W-1:0] digital_gain_exponent_a,
    output logic [GAIN_W-1:0] digital_gain_exponent_b,
    output logic [OUT_W-1:0] comp_out_a,
    output logic [OUT_W-1:0] comp_out_b
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic mr;
    logic si;
    logic exponent_inhibit;
    logic hold_initial_condition;
    logic [1:0] loop_gain_shift;
    logic [1:0] detector_comb_order;
    logic [DLY_W-1:0] compensation_delay;
    logic [RAM_W-1:0] integrator_init [0:CHANNELS-1];
    logic [RAM_W-1:0] gain_table [0:RAM_DEPTH-1];
    logic [DEC_W-1:0] dec_cnt;
    logic dec_tick;
    logic upd_tick;
    logic wr_en;
    logic setup;
    logic [31:0] next_rdata;
    logic next_err;
    logic [ADC_W-1:0] adc_in [0:CHANNELS-1];
    logic [MIX_W-1:0] mix_in [0:CHANNELS-1];
    logic [INT_W-1:0] integ [0:CHANNELS-1];
    logic [GAIN_W-1:0] gain_q [0:CHANNELS-1];
    logic strobe_q [0:CHANNELS-1];
    logic [GAIN_W-1:0] exp_q [0:CHANNELS-1];
    logic [OUT_W-1:0] comp_q [0:CHANNELS-1];

    assign mr = ~master_reset_n;
    assign si = ~sync_in_n;
    assign adc_in[0] = adc_a;
    assign adc_in[1] = adc_b;
    assign mix_in[0] = mixer_a;
    assign mix_in[1] = mixer_b;
    assign dec_tick = (dec_cnt == DEC_W'(DEC_RATIO - 1));
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite;

    // float conversion: exponent from leading one, mantissa below it
    function automatic logic [RAM_AW-1:0] to_float(
        input logic [DET_W-1:0] lvl
    );
        logic [RAM_AW-1:0] code;
        code = {3'h0, lvl[1:0]};
        for (int k = 2; k < DET_W; k++)
        begin
            if (lvl[k])
            begin
                code = {3'(k - 1), lvl[k-1 -: 2]};
            end
        end
        return code;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // apb slave: no wait cycles; read data comes from a flip-flop loaded in setup

    // ready is raised in the access phase that follows each setup
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            if (setup)
            begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= next_err;
            end
            else
            begin
                pslverr <= 1'b0;
            end
        end
    end

    // read decode; unmapped addresses read zero and flag an error
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (paddr[7])
        begin
            next_rdata = {24'h0, gain_table[paddr[6:2]]};
        end
        else
        begin
            unique case (paddr)
                OFS_CTRL:
                begin
                    next_rdata[CTRL_INH_BIT] = exponent_inhibit;
                    next_rdata[CTRL_HOLD_BIT] = hold_initial_condition;
                    next_rdata[CTRL_LG_LSB +: 2] = loop_gain_shift;
                end
                OFS_CTRL2:
                begin
                    next_rdata[CTRL2_ORD_LSB +: 2] = detector_comb_order;
                    next_rdata[CTRL2_DLY_LSB +: DLY_W] = compensation_delay;
                end
                OFS_IC_A: next_rdata = {24'h0, integrator_init[0]};
                OFS_IC_B: next_rdata = {24'h0, integrator_init[1]};
                OFS_RB_A: next_rdata = {24'h0, integ[0][INT_W-1 -: 8]};
                OFS_RB_B: next_rdata = {24'h0, integ[1][INT_W-1 -: 8]};
                default: next_err = 1'b1;
            endcase
        end
        if (paddr[1:0] != 2'h0)
        begin
            next_err = 1'b1;
        end
    end

    // control registers; master reset restores the defaults
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            exponent_inhibit <= INH_RST;
            hold_initial_condition <= HOLD_RST;
            loop_gain_shift <= LG_RST;
            detector_comb_order <= ORD_RST;
            compensation_delay <= DLY_RST;
            integrator_init[0] <= IC_RST;
            integrator_init[1] <= IC_RST;
        end
        else if (mr)
        begin
            exponent_inhibit <= INH_RST;
            hold_initial_condition <= HOLD_RST;
            loop_gain_shift <= LG_RST;
            detector_comb_order <= ORD_RST;
            compensation_delay <= DLY_RST;
            integrator_init[0] <= IC_RST;
            integrator_init[1] <= IC_RST;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                OFS_CTRL:
                begin
                    exponent_inhibit <= pwdata[CTRL_INH_BIT];
                    hold_initial_condition <= pwdata[CTRL_HOLD_BIT];
                    loop_gain_shift <= pwdata[CTRL_LG_LSB +: 2];
                end
                OFS_CTRL2:
                begin
                    detector_comb_order <= pwdata[CTRL2_ORD_LSB +: 2];
                    compensation_delay <= pwdata[CTRL2_DLY_LSB +: DLY_W];
                end
                OFS_IC_A: integrator_init[0] <= pwdata[7:0];
                OFS_IC_B: integrator_init[1] <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // lookup table, written by software only, no reset needed for data
    always_ff @(posedge ref_clk)
    begin
        if (wr_en && paddr[7] && paddr[1:0] == 2'h0)
        begin
            gain_table[paddr[6:2]] <= pwdata[RAM_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shared decimation timing

    // sync-in realigns the decimation phase of both detectors
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dec_cnt <= '0;
            upd_tick <= 1'b0;
        end
        else if (mr | si)
        begin
            dec_cnt <= '0;
            upd_tick <= 1'b0;
        end
        else
        begin
            dec_cnt <= dec_cnt + 1'b1;
            upd_tick <= dec_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per channel detector, integrator, amplifier and compensation

    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_ch
        logic [ADC_W-1:0] mag;
        logic [DET_W-1:0] det_in;
        logic [CIC_W-1:0] acc1;
        logic [CIC_W-1:0] acc2;
        logic [CIC_W-1:0] dly1;
        logic [CIC_W-1:0] dly2;
        logic [CIC_W-1:0] next_c1;
        logic [CIC_W-1:0] next_c2;
        logic [DET_W-1:0] lvl0;
        logic [DET_W-1:0] lvl1;
        logic [DET_W-1:0] lvl2;
        logic [DET_W-1:0] next_lvl0;
        logic [DET_W-1:0] next_lvl1;
        logic [DET_W-1:0] next_lvl2;
        logic [DET_W-1:0] detector_level;
        logic [RAM_AW-1:0] code;
        logic [SUM_W-1:0] err;
        logic [SUM_W-1:0] next_sum;
        logic [GAIN_W-1:0] next_gain;
        logic [GAIN_W-1:0] exp_sr [0:DLY_DEPTH-1];
        logic [GAIN_W-1:0] exp_tap;
        logic [OUT_W-1:0] mix_ext;

        // magnitude folded to nine bits; the lone most negative code
        // saturates instead of wrapping to zero
        assign mag = adc_in[ch][ADC_W-1] ? -adc_in[ch] : adc_in[ch];
        assign det_in = mag[ADC_W-1] ? '1 : mag[ADC_W-2:2];

        // comb differences; modular wrap of the integrators cancels here
        assign next_c1 = acc2 - dly1;
        assign next_c2 = next_c1 - dly2;
        assign next_lvl0 = next_c2[CIC_W-1:CIC_SHIFT];
        // extra averaging of decimated levels narrows the detector
        assign next_lvl1 = DET_W'(({1'b0, next_lvl0} + lvl0) >> 1);
        assign next_lvl2 = DET_W'(({1'b0, next_lvl1} + lvl1) >> 1);

        // two integrators at the clock rate, combs at one eighth
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                acc1 <= '0;
                acc2 <= '0;
                dly1 <= '0;
                dly2 <= '0;
                lvl0 <= '0;
                lvl1 <= '0;
                lvl2 <= '0;
            end
            else if (mr | si)
            begin
                acc1 <= '0;
                acc2 <= '0;
                dly1 <= '0;
                dly2 <= '0;
                lvl0 <= '0;
                lvl1 <= '0;
                lvl2 <= '0;
            end
            else
            begin
                acc1 <= acc1 + CIC_W'(det_in);
                acc2 <= acc2 + acc1;
                if (dec_tick)
                begin
                    dly1 <= acc2;
                    dly2 <= next_c1;
                    lvl0 <= next_lvl0;
                    lvl1 <= next_lvl1;
                    lvl2 <= next_lvl2;
                end
            end
        end

        // comb order select: 0 default, 1 and 2 successively narrower
        always_comb
        begin
            unique case (detector_comb_order)
                2'h0: detector_level = lvl0;
                2'h1: detector_level = lvl1;
                default: detector_level = lvl2;
            endcase
        end

        // table lookup, sign extension and loop gain shift
        assign code = to_float(detector_level);
        assign err = SUM_W'($signed(gain_table[code])) << loop_gain_shift;
        assign next_sum = SUM_W'({2'h0, integ[ch]}) + err;

        // integrator: hold reloads, otherwise one step per decimated level
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                integ[ch] <= '0;
            end
            else if (hold_initial_condition | mr)
            begin
                // top bits inverted so the amplifier sees the inverse
                integ[ch] <= {~integrator_init[ch][7:5],
                    integrator_init[ch][4:0], 3'h0};
            end
            else if (upd_tick)
            begin
                if (next_sum[SUM_W-1])
                begin
                    integ[ch] <= '0;
                end
                else if (next_sum[SUM_W-2:INT_W] != '0)
                begin
                    integ[ch] <= '1;
                end
                else
                begin
                    integ[ch] <= next_sum[INT_W-1:0];
                end
            end
        end

        assign next_gain = integ[ch][INT_W-1 -: GAIN_W];

        // strobe on a change of this channel's own word, and during master reset or sync-in
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                gain_q[ch] <= '0;
                strobe_q[ch] <= 1'b1;
            end
            else
            begin
                gain_q[ch] <= next_gain;
                strobe_q[ch] <= mr | si | (next_gain != gain_q[ch]);
            end
        end

        // exponent delay line; tap 0 bypasses the line entirely
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                for (int i = 0; i < DLY_DEPTH; i++)
                begin
                    exp_sr[i] <= EXP_UNITY;
                end
            end
            else
            begin
                exp_sr[0] <= ~gain_q[ch];
                for (int i = 1; i < DLY_DEPTH; i++)
                begin
                    exp_sr[i] <= exp_sr[i-1];
                end
            end
        end

        assign exp_tap = (compensation_delay == '0) ? ~gain_q[ch] :
            exp_sr[compensation_delay - 1'b1];
        assign mix_ext = OUT_W'($signed(mix_in[ch]));

        // compensation: inhibit pins the exponent at unity
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                exp_q[ch] <= EXP_UNITY;
                comp_q[ch] <= '0;
            end
            else
            begin
                exp_q[ch] <= exponent_inhibit ? EXP_UNITY : exp_tap;
                comp_q[ch] <= mix_ext << exp_q[ch];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all taken from flip-flops

    assign analog_gain_word_a = gain_q[0];
    assign analog_gain_word_b = gain_q[1];
    assign gain_latch_strobe_a = strobe_q[0];
    assign gain_latch_strobe_b = strobe_q[1];
    assign digital_gain_exponent_a = exp_q[0];
    assign digital_gain_exponent_b = exp_q[1];
    assign comp_out_a = comp_q[0];
    assign comp_out_b = comp_q[1];

endmodule

// [core/agl_pkg.sv]
// constants shared by the automatic gain loop design
package agl_pkg;

    // datapath widths
    localparam int ADC_W = 12;
    localparam int DET_W = 9;
    localparam int MIX_W = 15;
    localparam int OUT_W = 22;
    localparam int INT_W = 11;
    localparam int RAM_W = 8;
    localparam int RAM_DEPTH = 32;
    localparam int RAM_AW = 5;
    localparam int GAIN_W = 3;
    localparam int DLY_W = 5;
    localparam int DLY_DEPTH = 32;
    localparam int CHANNELS = 2;

    // detector comb: decimation and growth of two stages
    localparam int DEC_RATIO = 8;
    localparam int DEC_W = 3;
    localparam int CIC_W = 15;
    localparam int CIC_SHIFT = 6;
    localparam int SUM_W = 13;

    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_IC_A = 8'h08;
    localparam logic [7:0] OFS_IC_B = 8'h0C;
    localparam logic [7:0] OFS_RB_A = 8'h10;
    localparam logic [7:0] OFS_RB_B = 8'h14;
    localparam logic [7:0] OFS_TABLE = 8'h80;

    // field positions
    localparam int CTRL_INH_BIT = 0;
    localparam int CTRL_HOLD_BIT = 3;
    localparam int CTRL_LG_LSB = 4;
    localparam int CTRL2_ORD_LSB = 0;
    localparam int CTRL2_DLY_LSB = 2;

    // reset values
    localparam logic INH_RST = 1'b0;
    localparam logic HOLD_RST = 1'b0;
    localparam logic [1:0] LG_RST = 2'h0;
    localparam logic [1:0] ORD_RST = 2'h0;
    localparam logic [4:0] DLY_RST = 5'h00;
    localparam logic [7:0] IC_RST = 8'h00;
    localparam logic [2:0] EXP_UNITY = 3'h7;

endpackage

// [tb/agl_amp_model.sv]
// behavioural stepped gain amplifier that latches the gain word
`timescale 1ns/1ps
module agl_amp_model
    import agl_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // amplifier pins
    input wire logic [GAIN_W-1:0] gain_word,
    input wire logic latch_strobe,
    // latched state seen by the bench
    output logic [GAIN_W-1:0] held_gain,
    output int unsigned strobe_count
);
    initial strobe_count = 0;

    // word is taken only on a strobe, so a lost strobe leaves stale gain
    always @(posedge ref_clk)
    begin
        if (latch_strobe === 1'b1)
        begin
            held_gain <= gain_word;
            strobe_count <= strobe_count + 1;
        end
    end
endmodule

// [tb/agl_loop_props.sv]
// port timing checker for the automatic gain loop
`timescale 1ns/1ps
module agl_loop_props
    import agl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // control pins and amplifier side
    input wire logic master_reset_n,
    input wire logic sync_in_n,
    input wire logic [GAIN_W-1:0] analog_gain_word_a,
    input wire logic [GAIN_W-1:0] analog_gain_word_b,
    input wire logic gain_latch_strobe_a,
    input wire logic gain_latch_strobe_b
);
    ////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // loop runs freely only with both control pins released
    logic run;
    assign run = master_reset_n && sync_in_n;
    logic setup;
    assign setup = psel && !penable;

    ////////////////////////////////////////
    a_strobe_a_change: assert property (run && $past(run) |->
        gain_latch_strobe_a == (analog_gain_word_a !=
        $past(analog_gain_word_a)))
        else $error("strobe a does not follow its gain word");
    a_strobe_b_change: assert property (run && $past(run) |->
        gain_latch_strobe_b == (analog_gain_word_b !=
        $past(analog_gain_word_b)))
        else $error("strobe b does not follow its gain word");
    a_strobe_held: assert property (!run |=>
        gain_latch_strobe_a && gain_latch_strobe_b)
        else $error("strobes low during master reset or sync");
    a_ready_after: assert property (setup |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_misaligned: assert property (setup && paddr[1:0] != 2'h0
        |=> pslverr && pready)
        else $error("misaligned access not refused");
    a_err_control: assert property (setup && paddr == OFS_CTRL
        |=> !pslverr)
        else $error("control access refused");
    a_rdata_hold: assert property (!setup |=> $stable(prdata))
        else $error("read data moved outside a transfer");
endmodule

bind agl_loop agl_loop_props u_props (.ref_clk, .rst, .psel,
    .penable, .paddr, .prdata, .pready, .pslverr, .master_reset_n,
    .sync_in_n, .analog_gain_word_a, .analog_gain_word_b,
    .gain_latch_strobe_a, .gain_latch_strobe_b);

// [tb/testbench.sv]
// self-checking bench for the automatic gain loop
`timescale 1ns/1ps
module testbench
    import agl_pkg::*;
;
    // clock, reset and apb
    logic ref_clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // device pins
    logic master_reset_n;
    logic sync_in_n;
    logic [ADC_W-1:0] adc_a;
    logic [ADC_W-1:0] adc_b;
    logic [MIX_W-1:0] mixer_a;
    logic [MIX_W-1:0] mixer_b;
    logic [GAIN_W-1:0] word_a;
    logic [GAIN_W-1:0] word_b;
    logic stb_a;
    logic stb_b;
    logic [GAIN_W-1:0] exp_a;
    logic [GAIN_W-1:0] exp_b;
    logic [OUT_W-1:0] comp_a;
    logic [OUT_W-1:0] comp_b;
    // partner state and bookkeeping
    logic [GAIN_W-1:0] held_a;
    logic [GAIN_W-1:0] held_b;
    int unsigned cnt_a;
    int unsigned cnt_b;
    int err_count;
    int comparisons;
    logic [31:0] q;
    logic e;

    ////////////////////////////////////////
    agl_loop uut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .master_reset_n(master_reset_n),
        .sync_in_n(sync_in_n), .adc_a(adc_a), .adc_b(adc_b),
        .mixer_a(mixer_a), .mixer_b(mixer_b),
        .analog_gain_word_a(word_a), .analog_gain_word_b(word_b),
        .gain_latch_strobe_a(stb_a), .gain_latch_strobe_b(stb_b),
        .digital_gain_exponent_a(exp_a),
        .digital_gain_exponent_b(exp_b),
        .comp_out_a(comp_a), .comp_out_b(comp_b));
    agl_amp_model amp_a (.ref_clk(ref_clk), .gain_word(word_a),
        .latch_strobe(stb_a), .held_gain(held_a), .strobe_count(cnt_a));
    agl_amp_model amp_b (.ref_clk(ref_clk), .gain_word(word_b),
        .latch_strobe(stb_b), .held_gain(held_b), .strobe_count(cnt_b));

    ////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic chk(input string s, input logic [31:0] x, y);
        comparisons++;
        if (x !== y)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, x, y);
        end
    endtask

    // one apb transfer; entered just after an edge with the bus idle
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic f);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        // no wait limit here: only the watchdog ends a stalled transfer
        while (pready !== 1'b1)
            @(posedge ref_clk);
        r = prdata;
        f = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic f;
        apb(1'b1, a, d, r, f);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic f;
        apb(1'b0, a, 32'h00000000, r, f);
    endtask

    task automatic fill(input logic [7:0] v);
        for (int i = 0; i < RAM_DEPTH; i++)
            wr(OFS_TABLE + 8'(i * 4), {24'h000000, v});
    endtask

    // setups 80 clocks apart always span exactly ten loop updates
    task automatic step_rate(input string s);
        logic [31:0] r0;
        rd(OFS_RB_A, r0);
        tick(77);
        rd(OFS_RB_A, q);
        chk(s, 32'h0000000A, q - r0);
    endtask

    function automatic logic [21:0] place(input logic [14:0] m,
        input logic [2:0] x);
        return {{7{m[14]}}, m} << x;
    endfunction

    ////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] regs [4] = '{OFS_CTRL, OFS_CTRL2, OFS_IC_A, OFS_IC_B};
        chk("strobe a in reset", 1, stb_a);
        chk("strobe b in reset", 1, stb_b);
        fill(8'h00);
        chk("word a in reset", 7, word_a);
        master_reset_n <= 1'b1;
        tick(2);
        foreach (regs[i])
        begin
            rd(regs[i], q);
            chk("reset value", 0, q);
        end
        apb(1'b0, 8'h18, 32'h00000000, q, e);
        chk("unmapped error", 1, e);
        apb(1'b1, 8'h06, 32'h00000000, q, e);
        chk("misaligned error", 1, e);
        wr(OFS_RB_A, 32'h00000000);
        rd(OFS_RB_A, q);
        chk("readback a", 32'hE0, q);
        chk("held gain a", 7, held_a);
    endtask

    task automatic t_fixed;
        int unsigned ca;
        int unsigned cb;
        ca = cnt_a;
        cb = cnt_b;
        wr(OFS_IC_A, 32'h000000A0);
        wr(OFS_CTRL, 32'h00000008);
        tick(4);
        chk("fixed word a", 2, word_a);
        chk("fixed word b", 7, word_b);
        chk("held gain a", 2, held_a);
        chk("strobes a", ca + 1, cnt_a);
        chk("strobes b", cb, cnt_b);
        rd(OFS_RB_A, q);
        chk("readback a", 32'h40, q);
    endtask

    task automatic t_exp;
        int n;
        chk("exponent a", 5, exp_a);
        chk("exponent b", 0, exp_b);
        mixer_a <= 15'h4321;
        mixer_b <= 15'h1234;
        tick(3);
        chk("placed a", place(15'h4321, 5), comp_a);
        chk("placed b", place(15'h1234, 0), comp_b);
        wr(OFS_CTRL, 32'h00000009);
        tick(3);
        chk("inhibited", 7, exp_a);
        chk("placed unity", place(15'h4321, 7), comp_a);
        wr(OFS_CTRL, 32'h00000008);
        wr(OFS_CTRL2, 32'h00000020);
        tick(12);
        wr(OFS_IC_A, 32'h000000E0);
        n = 0;
        while (word_a !== 3'h0 && n < 10)
        begin
            n++;
            @(posedge ref_clk);
        end
        n = 0;
        while (exp_a !== 3'h7 && n < 20)
        begin
            n++;
            @(posedge ref_clk);
        end
        chk("exponent delay", 1, n >= 7 && n <= 11);
    endtask

    task automatic t_free;
        for (int g = 0; g < 4; g++)
        begin
            fill(8'(8 >> g));
            wr(OFS_CTRL, 32'(g << 4));
            step_rate("loop gain step");
        end
        rd(OFS_RB_B, q);
        chk("b at ceiling", 32'hFF, q);
    endtask

    task automatic t_code;
        logic [8:0] lv [4] = '{9'd3, 9'd6, 9'd100, 9'd432};
        logic [4:0] cd [4] = '{5'd3, 5'd6, 5'd22, 5'd30};
        fill(8'h00);
        wr(OFS_CTRL2, 32'h00000022);
        wr(OFS_CTRL, 32'h00000008);
        wr(OFS_CTRL, 32'h00000000);
        foreach (lv[i])
        begin
            adc_a <= i[0] ? -ADC_W'({lv[i], 2'b00}) :
                ADC_W'({lv[i], 2'b00});
            wr(OFS_TABLE + 8'(cd[i] * 4), 32'h00000008);
            tick(64);
            step_rate("float code");
            wr(OFS_TABLE + 8'(cd[i] * 4), 32'h00000000);
        end
    endtask

    task automatic t_sat;
        logic [7:0] tv [2] = '{8'h80, 8'h7F};
        adc_a <= 12'h000;
        wr(OFS_CTRL, 32'h00000030);
        foreach (tv[i])
        begin
            fill(tv[i]);
            tick(40);
            rd(OFS_RB_A, q);
            chk("saturated a", i != 0 ? 32'hFF : 32'h00, q);
            chk("saturated word", i != 0 ? 7 : 0, word_a);
        end
    endtask

    task automatic t_sync;
        sync_in_n <= 1'b0;
        tick(3);
        chk("sync strobe a", 1, stb_a);
        chk("sync strobe b", 1, stb_b);
        sync_in_n <= 1'b1;
        tick(3);
        chk("strobe released", 0, stb_a);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////
    // free-running clock
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // hang guard, far beyond the few thousand clocks the tests need
    initial
    begin
        tick(20000);
        err_count++;
        report_and_stop;
    end

    // master reset held low so the loop starts from a known gain
    initial
    begin
        err_count = 0;
        comparisons = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        master_reset_n = 1'b0;
        sync_in_n = 1'b1;
        adc_a = 12'h000;
        adc_b = 12'h000;
        mixer_a = 15'h0000;
        mixer_b = 15'h0000;
        tick(5);
        rst <= 1'b0;
        tick(1);
        t_reset;
        t_fixed;
        t_exp;
        t_free;
        t_code;
        t_sat;
        t_sync;
        report_and_stop;
    end
endmodule
